// ---- verilog/sce_encoder.sv ----
// transmit line coder: byte scrambler followed by 8b/10b encoder
// inputs come from logic on the same clock; one character per clock
`timescale 1ns/1ps
`default_nettype none
module sce_encoder (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic in_k,
  input wire logic [7:0] in_data,
  input wire logic frame_start,
  input wire logic scramble_en,
  output logic [9:0] enc_char,
  output logic enc_valid,
  output logic run_disp,
  output logic kcode_err,
  output logic comma
);

  ////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [3:0] ones10(input logic [9:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 10; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  function automatic logic [5:0] rev6(input logic [5:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 6; i++) begin
      r[i] = v[5 - i];
    end
    return r;
  endfunction

  function automatic logic [3:0] rev4(input logic [3:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 4; i++) begin
      r[i] = v[3 - i];
    end
    return r;
  endfunction

  // true when a run longer than the limit appears in two characters
  function automatic logic long_run(input logic [19:0] s);
    int run;
    logic hit;
    run = 1;
    hit = 1'h0;
    for (int i = 1; i < 20; i++) begin
      run = (s[i] == s[i - 1]) ? run + 1 : 1;
      if (run > sce_pkg::SCE_RUN_MAX) begin
        hit = 1'h1;
      end
    end
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state

  sce_pkg::sce_state_s st_ff;
  sce_pkg::sce_state_s nxt_st;

  logic [15:0] seed_in;
  logic [15:0] lfsr_adv;
  logic [7:0] key;
  logic [7:0] scr;
  logic [4:0] low;
  logic [2:0] high;
  logic k28;
  logic k_ok;
  logic [5:0] code6;
  logic [5:0] six;
  logic [3:0] w6;
  logic rd6;
  logic alt7;
  logic [3:0] code4;
  logic [3:0] four;
  logic [3:0] w4;
  logic rd_new;

  sce_lfsr_step u_step (
    .state_in(seed_in),
    .key(key),
    .state_out(lfsr_adv)
  );

  ////////////////////////////////////////////////////////////////////
  // scrambler

  always_comb begin
    // reseed on frame start so the first byte uses the seed itself
    seed_in = frame_start ? sce_pkg::SCE_SEED : st_ff.lfsr;
    // control characters pass unscrambled so they stay recognisable
    scr = (in_k || !scramble_en) ? in_data : (in_data ^ key);
    low = scr[sce_pkg::SCE_LOW_MSB:sce_pkg::SCE_LOW_LSB];
    high = scr[sce_pkg::SCE_HIGH_MSB:sce_pkg::SCE_HIGH_LSB];
  end

  ////////////////////////////////////////////////////////////////////
  // 5b/6b stage

  always_comb begin
    k28 = in_k && (low == sce_pkg::SCE_LOW_K28);
    k_ok = k28 || (in_k && (high == sce_pkg::SCE_HIGH_X7) &&
      ((low == sce_pkg::SCE_LOW_K23) || (low == sce_pkg::SCE_LOW_K27) ||
       (low == sce_pkg::SCE_LOW_K29) || (low == sce_pkg::SCE_LOW_K30)));
    // control 28 is not a bit mapping of its input
    code6 = k28 ? sce_pkg::SCE_K28_6 : sce_pkg::SCE_D6[low];
    w6 = ones10({4'h0, code6});
    if (w6 == sce_pkg::SCE_W_BAL6) begin
      // balanced codes fixed, except D07 which flips with disparity
      if (!k28 && (low == sce_pkg::SCE_LOW_D07) && st_ff.rd) begin
        six = ~code6;
      end else begin
        six = code6;
      end
      rd6 = st_ff.rd;
    end else begin
      // heavy form under negative disparity, complement under positive
      six = st_ff.rd ? ~code6 : code6;
      rd6 = ~st_ff.rd;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // 3b/4b stage

  always_comb begin
    alt7 = 1'h0;
    if (!k_ok && (high == sce_pkg::SCE_HIGH_X7)) begin
      // alternate x.7 forms break up a run of five equal bits
      if (!rd6) begin
        alt7 = (low == sce_pkg::SCE_ALT_N0) || (low == sce_pkg::SCE_ALT_N1) ||
          (low == sce_pkg::SCE_ALT_N2);
      end else begin
        alt7 = (low == sce_pkg::SCE_ALT_P0) || (low == sce_pkg::SCE_ALT_P1) ||
          (low == sce_pkg::SCE_ALT_P2);
      end
    end
    if (k_ok) begin
      code4 = sce_pkg::SCE_K4[high];
    end else if (alt7) begin
      code4 = sce_pkg::SCE_D7_ALT;
    end else begin
      code4 = sce_pkg::SCE_D4[high];
    end
    w4 = ones10({6'h00, code4});
    // complement under positive disparity unless balanced and fixed
    if (!rd6) begin
      four = code4;
    end else if (!k_ok && (w4 == sce_pkg::SCE_W_BAL4) &&
                 (high != sce_pkg::SCE_HIGH_X3)) begin
      four = code4;
    end else begin
      four = ~code4;
    end
    // new running disparity from the four-bit part
    if (ones10({6'h00, four}) == sce_pkg::SCE_W_HEAVY4) begin
      rd_new = 1'h1;
    end else if (ones10({6'h00, four}) == sce_pkg::SCE_W_BAL4) begin
      rd_new = rd6;
    end else begin
      rd_new = 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state update

  always_comb begin
    nxt_st = st_ff;
    nxt_st.vld = in_valid;
    if (in_valid) begin
      nxt_st.lfsr = lfsr_adv;
      // a,b,c,d,e,i in bits 0..5, f,g,h,j in bits 6..9, bit 0 sent first
      nxt_st.chr = {rev4(four), rev6(six)};
      nxt_st.rd = rd_new;
      nxt_st.kerr = in_k && !k_ok;
      nxt_st.comma = k28;
    end else begin
      // reseed held over to the next character when idle
      nxt_st.lfsr = seed_in;
      nxt_st.kerr = 1'h0;
      nxt_st.comma = 1'h0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff.lfsr <= sce_pkg::SCE_SEED;
      st_ff.rd <= sce_pkg::SCE_RD_RST;
      st_ff.chr <= sce_pkg::SCE_CHAR_RST;
      st_ff.vld <= 1'h0;
      st_ff.kerr <= 1'h0;
      st_ff.comma <= 1'h0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign enc_char = st_ff.chr;
  assign enc_valid = st_ff.vld;
  assign run_disp = st_ff.rd;
  assign kcode_err = st_ff.kerr;
  assign comma = st_ff.comma;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_seed_first_key: assert property (
    in_valid && frame_start && !in_k && scramble_en |-> scr == (in_data ^ sce_pkg::SCE_KEY_AT_SEED))
    else $error("first byte of frame not scrambled with seed key");

  a_scramble_xor: assert property (
    in_valid && !in_k && scramble_en |-> scr == (in_data ^ key))
    else $error("data byte not combined with generator output");

  a_weight_legal: assert property (
    enc_valid |-> (ones10(enc_char) >= sce_pkg::SCE_W_LIGHT) &&
      (ones10(enc_char) <= sce_pkg::SCE_W_HEAVY))
    else $error("character weight outside four to six");

  a_rd_follows: assert property (
    enc_valid && (ones10(enc_char) != sce_pkg::SCE_W_BAL) |->
      run_disp == (ones10(enc_char) == sce_pkg::SCE_W_HEAVY))
    else $error("running disparity disagrees with unbalanced character");

  a_rd_balanced: assert property (
    enc_valid && $past(in_valid) && (ones10(enc_char) == sce_pkg::SCE_W_BAL) |->
      $stable(run_disp))
    else $error("balanced character changed running disparity");

  a_unbal_choice: assert property (
    in_valid ##1 (ones10(enc_char) != sce_pkg::SCE_W_BAL) |->
      (ones10(enc_char) == sce_pkg::SCE_W_LIGHT) == $past(run_disp))
    else $error("wrong variant for running disparity");

  a_six_choice: assert property (
    in_valid ##1 (ones10({4'h0, enc_char[5:0]}) != sce_pkg::SCE_W_BAL6) |->
      (ones10({4'h0, enc_char[5:0]}) == sce_pkg::SCE_W_LIGHT) == !$past(run_disp))
    else $error("six-bit variant does not match disparity");

  a_d07_forms: assert property (
    in_valid && !in_k && low == sce_pkg::SCE_LOW_D07 |=>
      enc_char[5:0] == ($past(run_disp) ? 6'h38 : 6'h07))
    else $error("D07 six-bit form wrong for disparity");

  a_k28_form: assert property (
    in_valid && k28 |=> (enc_char[5:0] == 6'h3C) || (enc_char[5:0] == 6'h03))
    else $error("K28 six-bit code not the special form");

  a_four_codes: assert property (
    enc_valid |-> (enc_char[9:6] != 4'h0) && (enc_char[9:6] != 4'hF))
    else $error("four-bit code outside the legal set");

  a_alt_neg: assert property (
    in_valid && !k_ok && high == sce_pkg::SCE_HIGH_X7 && !run_disp &&
      (low == sce_pkg::SCE_ALT_N0 || low == sce_pkg::SCE_ALT_N1 ||
       low == sce_pkg::SCE_ALT_N2) |=> enc_char[9:6] == 4'hE)
    else $error("negative alternate x.7 code missing");

  a_alt_pos: assert property (
    in_valid && !k_ok && high == sce_pkg::SCE_HIGH_X7 && run_disp &&
      (low == sce_pkg::SCE_ALT_P0 || low == sce_pkg::SCE_ALT_P1 ||
       low == sce_pkg::SCE_ALT_P2) |=> enc_char[9:6] == 4'h1)
    else $error("positive alternate x.7 code missing");

  a_run_limit: assert property (
    enc_valid && $past(enc_valid) |-> !long_run({enc_char, $past(enc_char)}))
    else $error("more than five equal bits in a row");

  a_one_per_clk: assert property (
    in_valid |=> enc_valid ##0 ($past(in_valid) == enc_valid))
    else $error("accepted byte produced no character");

  a_idle_quiet: assert property (
    !in_valid |=> !enc_valid && !kcode_err && !comma)
    else $error("character emitted without input");

endmodule
`default_nettype wire

// ---- verilog/sce_pkg.sv ----
// constants, tables and state type for the scrambling 8b/10b line encoder
// assumes a single clock domain; used by sce_encoder and sce_lfsr_step
// How it works
// - data bytes XORed with generator output first
// - generator reloaded with seed each frame
// - sixteen-stage LFSR, taps 16, 5, 4, 3
// - seeding sets every generator flip-flop to one
// - every character has four, five or six ones
// - running disparity follows last unbalanced character
// - balanced characters leave running disparity alone
// - unbalanced: four ones if positive, six if negative
// - low five bits encoded first, using K and disparity
// - six-bit code fills the low six positions
// - high three bits become top four, update disparity
// - unbalanced six-bit: heavy if negative, complement otherwise
// - balanced six-bit fixed, except D07 two forms
// - control 28 has its own six-bit codes
// - unbalanced four-bit: heavy after negative six-bit disparity
// - only fourteen distinct four-bit codes appear
// - D17/18/20.7 negative use alternate 0111 code
// - D11/13/14.7 positive use alternate 1000 code
// - never more than five equal bits in a row
package sce_pkg;

  // generator
  localparam logic [15:0] SCE_SEED = 16'hFFFF;
  localparam logic [15:0] SCE_TAPS = 16'h0039;
  localparam int SCE_KEY_BITS = 8;
  localparam logic [7:0] SCE_KEY_AT_SEED = 8'hFF;

  // reset values
  localparam logic SCE_RD_RST = 1'h0;
  localparam logic [9:0] SCE_CHAR_RST = 10'h000;

  // input field positions
  localparam int SCE_LOW_LSB = 0;
  localparam int SCE_LOW_MSB = 4;
  localparam int SCE_HIGH_LSB = 5;
  localparam int SCE_HIGH_MSB = 7;

  // special input values
  localparam logic [4:0] SCE_LOW_K28 = 5'h1C;
  localparam logic [4:0] SCE_LOW_D07 = 5'h07;
  localparam logic [4:0] SCE_LOW_K23 = 5'h17;
  localparam logic [4:0] SCE_LOW_K27 = 5'h1B;
  localparam logic [4:0] SCE_LOW_K29 = 5'h1D;
  localparam logic [4:0] SCE_LOW_K30 = 5'h1E;
  localparam logic [2:0] SCE_HIGH_X7 = 3'h7;
  localparam logic [2:0] SCE_HIGH_X3 = 3'h3;
  localparam logic [4:0] SCE_ALT_N0 = 5'h11;
  localparam logic [4:0] SCE_ALT_N1 = 5'h12;
  localparam logic [4:0] SCE_ALT_N2 = 5'h14;
  localparam logic [4:0] SCE_ALT_P0 = 5'h0B;
  localparam logic [4:0] SCE_ALT_P1 = 5'h0D;
  localparam logic [4:0] SCE_ALT_P2 = 5'h0E;

  // codes for negative disparity, printed order (a or f is the msb)
  localparam logic [5:0] SCE_D6 [0:31] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [5:0] SCE_K28_6 = 6'h0F;
  localparam logic [3:0] SCE_D4 [0:7] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  localparam logic [3:0] SCE_K4 [0:7] = '{
    4'hB, 4'h6, 4'hA, 4'hC, 4'hD, 4'h5, 4'h9, 4'h7};
  localparam logic [3:0] SCE_D7_ALT = 4'h7;

  // weights
  localparam logic [3:0] SCE_W_BAL6 = 4'h3;
  localparam logic [3:0] SCE_W_BAL4 = 4'h2;
  localparam logic [3:0] SCE_W_HEAVY4 = 4'h3;
  localparam logic [3:0] SCE_W_LIGHT = 4'h4;
  localparam logic [3:0] SCE_W_BAL = 4'h5;
  localparam logic [3:0] SCE_W_HEAVY = 4'h6;
  localparam int SCE_RUN_MAX = 5;

  typedef struct packed {
    logic [15:0] lfsr;
    logic rd;
    logic [9:0] chr;
    logic vld;
    logic kerr;
    logic comma;
  } sce_state_s;

endpackage

// ---- verilog/sce_lfsr_step.sv ----
// one character step of the scrambling generator: eight key bits out
// purely combinational; the caller holds the generator register
`timescale 1ns/1ps
`default_nettype none
module sce_lfsr_step (
  input wire logic [15:0] state_in,
  output logic [7:0] key,
  output logic [15:0] state_out
);

  always_comb begin
    logic [15:0] s;
    s = state_in;
    key = 8'h00;
    for (int i = 0; i < sce_pkg::SCE_KEY_BITS; i++) begin
      key[i] = s[15];
      // galois step, feedback x^16 + x^5 + x^4 + x^3 + 1
      s = {s[14:0], 1'h0} ^ (s[15] ? sce_pkg::SCE_TAPS : 16'h0000);
    end
    state_out = s;
  end

endmodule
`default_nettype wire

// ---- dv/sce_rx_model.sv ----
// far-end receiver model: decodes characters, tracks disparity, descrambles
// assumes it watches the encoder outputs and the frame marks on one clock
`timescale 1ns/1ps
`default_nettype none
module sce_rx_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [9:0] enc_char,
  input wire logic enc_valid,
  input wire logic run_disp,
  input wire logic kcode_err,
  input wire logic comma,
  input wire logic frame_start,
  input wire logic scramble_en
);
  logic [9:0] got_q [$];
  int n_err = 0;
  logic [15:0] lfsr = 16'hFFFF;
  logic pend = 1'h1;
  logic rd = 1'h0;
  logic last_bit = 1'h0;
  int run = 0;

  function automatic logic [10:0] encode(input logic [7:0] b, input logic k, input logic rdi);
    logic [5:0] six;
    logic [3:0] four;
    logic [4:0] lo;
    logic r6, kv, alt;
    logic [10:0] r;
    lo = b[4:0];
    kv = k && (lo == 5'h1C || (b[7:5] == 3'h7 && lo inside {5'h17, 5'h1B, 5'h1D, 5'h1E}));
    six = (kv && lo == 5'h1C) ? sce_pkg::SCE_K28_6 : sce_pkg::SCE_D6[lo];
    if (rdi && ($countones(six) != 3 || lo == 5'h07)) begin
      six = ~six;
    end
    r6 = ($countones(six) != 3) ? ~rdi : rdi;
    alt = r6 ? (lo inside {5'h0B, 5'h0D, 5'h0E}) : (lo inside {5'h11, 5'h12, 5'h14});
    four = kv ? sce_pkg::SCE_K4[b[7:5]] : sce_pkg::SCE_D4[b[7:5]];
    if (!kv && b[7:5] == 3'h7 && alt) begin
      four = 4'h7;
    end
    if (r6 && ($countones(four) != 2 || kv || b[7:5] == 3'h3)) begin
      four = ~four;
    end
    r[10] = ($countones(four) != 2) ? ~r6 : r6;
    r[5:0] = {<<{six}};
    r[9:6] = {<<{four}};
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock or posedge rst) begin
    logic [10:0] e;
    logic [15:0] s;
    logic [8:0] d;
    logic [7:0] key;
    logic hit, bad_rd;
    if (rst) begin
      rd = 1'h0;
      pend = 1'h1;
      run = 0;
    end else begin
      if (enc_valid) begin
        hit = 1'h0;
        bad_rd = 1'h0;
        d = 9'h000;
        // right disparity searched first, the wrong one only after
        for (int c = 0; c < 1024; c++) begin
          e = encode(c[7:0], c[8], rd ^ c[9]);
          if (!hit && e[9:0] === enc_char) begin
            hit = 1'h1;
            bad_rd = c[9];
            d = c[8:0];
            rd = e[10];
          end
        end
        if (!hit || bad_rd || run_disp !== rd) begin
          n_err++;
        end
        if (comma !== (d[8] && d[4:0] == 5'h1C)) begin
          n_err++;
        end
        for (int i = 0; i < 10; i++) begin
          run = (enc_char[i] == last_bit) ? run + 1 : 1;
          last_bit = enc_char[i];
          if (run > 5) begin
            n_err++;
          end
        end
        s = pend ? 16'hFFFF : lfsr;
        for (int i = 0; i < 8; i++) begin
          key[i] = s[15];
          s = {s[14:0], 1'h0} ^ (s[15] ? 16'h0039 : 16'h0000);
        end
        lfsr = s;
        pend = 1'h0;
        if (!d[8] && scramble_en) begin
          d[7:0] = d[7:0] ^ key;
        end
        got_q.push_back({kcode_err, d});
      end
      if (frame_start) begin
        pend = 1'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/sce_encoder_test.sv ----
// self-checking bench for the scrambling line encoder
// assumes sce_pkg, the encoder and the receiver model are compiled first
`timescale 1ns/1ps
`default_nettype none
module sce_encoder_test;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic in_valid = 1'h0;
  logic in_k = 1'h0;
  logic [7:0] in_data = 8'h00;
  logic frame_start = 1'h0;
  logic scramble_en = 1'h0;
  logic [9:0] enc_char;
  logic enc_valid, run_disp, kcode_err, comma;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [9:0] exp_q [$];

  always #5 clock = ~clock;

  sce_encoder dut_u (.clock(clock), .rst(rst), .in_valid(in_valid), .in_k(in_k),
    .in_data(in_data), .frame_start(frame_start), .scramble_en(scramble_en),
    .enc_char(enc_char), .enc_valid(enc_valid), .run_disp(run_disp),
    .kcode_err(kcode_err), .comma(comma));
  sce_rx_model part_u (.clock(clock), .rst(rst), .enc_char(enc_char),
    .enc_valid(enc_valid), .run_disp(run_disp), .kcode_err(kcode_err), .comma(comma),
    .frame_start(frame_start), .scramble_en(scramble_en));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic send(input logic [7:0] b, input logic k, input logic bad, input logic f);
    @(negedge clock);
    in_valid = 1'h1;
    in_k = k;
    in_data = b;
    frame_start = f;
    exp_q.push_back({bad, k & ~bad, b});
  endtask

  task automatic pause(input logic f);
    @(negedge clock);
    in_valid = 1'h0;
    in_k = 1'h0;
    frame_start = f;
  endtask

  task automatic drain();
    pause(1'h0);
    repeat (3) @(negedge clock);
    check(part_u.got_q.size(), exp_q.size());
    while (exp_q.size() > 0 && part_u.got_q.size() > 0) begin
      check(part_u.got_q.pop_front(), exp_q.pop_front());
    end
    exp_q.delete();
    part_u.got_q.delete();
    check(part_u.n_err, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_first();
    scramble_en = 1'h1;
    send(8'h00, 1'h0, 1'h0, 1'h1);
    pause(1'h0);
    check(enc_valid, 1'h1);
    check(enc_char, 10'h235);
    check(run_disp, 1'h0);
    pause(1'h0);
    check(enc_valid, 1'h0);
    drain();
  endtask

  task automatic s_data();
    logic [4:0] alts [6] = '{5'h0B, 5'h0D, 5'h0E, 5'h11, 5'h12, 5'h14};
    scramble_en = 1'h0;
    for (int b = 0; b < 256; b++) begin
      send(b[7:0], 1'h0, 1'h0, 1'h0);
    end
    // each character flips disparity, so the second sees the other sign
    foreach (alts[i]) begin
      send({3'h7, alts[i]}, 1'h0, 1'h0, 1'h0);
      send({3'h7, alts[i]}, 1'h0, 1'h0, 1'h0);
    end
    send(8'h00, 1'h1, 1'h1, 1'h0);
    send(8'h3D, 1'h1, 1'h1, 1'h0);
    drain();
  endtask

  task automatic s_kcodes();
    logic [7:0] ks [4] = '{8'hF7, 8'hFB, 8'hFD, 8'hFE};
    scramble_en = 1'h1;
    send(8'h5A, 1'h0, 1'h0, 1'h1);
    for (int r = 0; r < 2; r++) begin
      for (int h = 0; h < 8; h++) begin
        send({h[2:0], 5'h1C}, 1'h1, 1'h0, 1'h0);
      end
      foreach (ks[i]) begin
        send(ks[i], 1'h1, 1'h0, 1'h0);
      end
      send(8'h9C, 1'h0, 1'h0, 1'h0);
    end
    drain();
  endtask

  task automatic s_frames();
    for (int i = 0; i < 24; i++) begin
      send(8'h5B ^ i[7:0], 1'h0, 1'h0, i == 9);
    end
    pause(1'h1);
    pause(1'h0);
    for (int i = 0; i < 6; i++) begin
      send(8'hC4 + i[7:0], 1'h0, 1'h0, 1'h0);
    end
    drain();
  endtask

  task automatic s_reset();
    send(8'h3C, 1'h0, 1'h0, 1'h0);
    send(8'h1C, 1'h1, 1'h0, 1'h0);
    @(negedge clock);
    rst = 1'h1;
    in_valid = 1'h0;
    repeat (2) @(negedge clock);
    check(enc_valid, 1'h0);
    check(enc_char, 10'h000);
    check(run_disp, 1'h0);
    check({kcode_err, comma}, 2'h0);
    rst = 1'h0;
    exp_q.delete();
    part_u.got_q.delete();
    send(8'h00, 1'h0, 1'h0, 1'h0);
    pause(1'h0);
    check(enc_char, 10'h235);
    drain();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst = 1'h0;
    s_first();
    s_data();
    s_kcodes();
    s_frames();
    s_reset();
    close_out();
  end

  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
